// ==== hdl/aiar_router.sv ====
// Analog input role router with frequency command wire break detection
// How it works
// - Roles 13/14 give upper/lower frequency limit
// - Role 20 gives scaled monitor readable by bus
// - Role 30 gives internal PID feedback two
// - Roles 31/32 give internal PID auxiliary terms
// - Roles 41-43 feed external PID channel one
// - Roles 44-46 feed external PID channel two
// - Roles 47-49 feed external PID channel three
// - Channel one feedbacks combine: sum, diff, avg, max, min
// - Duplicate roles: terminal A beats B beats C
// - Drop below tenth in window means break
// - Command level resampled as reference at each window end while following with no drop
// - Level above recovery threshold ends the break
// - Fallback: decelerate, ratio 20 to 120, cancel
// - Cancel flags loss but passes command unchanged
// - Decel or cancel recover at 0.2 of sample
// - Ratio 100 or more recovers at sample level
// - Break check uses unfiltered input samples
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
module aiar_router #(
  parameter int LOSS_WINDOW_CYCLES = aiar_pkg::LOSS_WINDOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [11:0] analog_in_a,
  input wire logic [11:0] current_input_b,
  input wire logic [11:0] voltage_input_c,
  output logic [11:0] upper_limit_val,
  output logic upper_limit_vld,
  output logic [11:0] lower_limit_val,
  output logic lower_limit_vld,
  output logic [11:0] pid_fb2_val,
  output logic pid_fb2_vld,
  output logic [11:0] pid_aux1_val,
  output logic pid_aux1_vld,
  output logic [11:0] pid_aux2_val,
  output logic pid_aux2_vld,
  output logic [11:0] ext1_cmd_val,
  output logic ext1_cmd_vld,
  output logic [13:0] ext1_fb_val,
  output logic ext1_fb_vld,
  output logic [11:0] ext1_man_val,
  output logic ext1_man_vld,
  output logic [11:0] ext2_cmd_val,
  output logic ext2_cmd_vld,
  output logic [11:0] ext2_fb_val,
  output logic ext2_fb_vld,
  output logic [11:0] ext2_man_val,
  output logic ext2_man_vld,
  output logic [11:0] ext3_cmd_val,
  output logic ext3_cmd_vld,
  output logic [11:0] ext3_fb_val,
  output logic ext3_fb_vld,
  output logic [11:0] ext3_man_val,
  output logic ext3_man_vld,
  output logic [11:0] freq_cmd_out,
  output logic ref_loss,
  output logic irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [11:0] ain_raw [3];
  logic [11:0] ain_s1_reg [3];
  logic [11:0] ain_s2_reg [3];
  assign ain_raw[0] = analog_in_a;
  assign ain_raw[1] = current_input_b;
  assign ain_raw[2] = voltage_input_c;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] role_reg;
  logic [1:0] fb_mode_reg;
  logic [6:0] fb_ratio_reg;
  logic [2:0] combine_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [15:0] disp_coef_reg;
  logic [31:0] monitor_reg;
  logic [11:0] f1_reg;
  localparam int WIN_CNT_W_L = aiar_pkg::WIN_CNT_W;
  logic [WIN_CNT_W_L-1:0] win_cnt_reg;
  aiar_pkg::aiar_loss_state_t loss_state_reg;
  logic [11:0] routed_val_reg [aiar_pkg::NUM_ROLE];
  logic routed_vld_reg [aiar_pkg::NUM_ROLE];
  logic [13:0] ext1_fb_reg;
  logic [11:0] freq_reg;
  logic irq_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  logic [5:0] role_a;
  logic [5:0] role_b;
  logic [5:0] role_c;
  logic [1:0] freq_src;
  logic [11:0] cur;
  logic win_tick;
  logic drop_hit;
  logic recover_hit;
  logic loss_evt;
  logic repair_evt;
  logic bus_req;
  logic bus_wr;

  assign role_a = role_reg[aiar_pkg::ROLE_A_LSB +: 6];
  assign role_b = role_reg[aiar_pkg::ROLE_B_LSB +: 6];
  assign role_c = role_reg[aiar_pkg::ROLE_C_LSB +: 6];
  assign freq_src = role_reg[aiar_pkg::FREQ_SRC_LSB +: 2];
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  // Write lands at the edge where the master samples ack high
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

  genvar gt;
  generate
    for (gt = 0; gt < aiar_pkg::NUM_TERM; gt++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          ain_s1_reg[gt] <= 12'h000;
          ain_s2_reg[gt] <= 12'h000;
        end
        else
        begin
          ain_s1_reg[gt] <= ain_raw[gt];
          ain_s2_reg[gt] <= ain_s1_reg[gt];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Role routing, one entry per destination
  // ----------------------------------------------------------------
  genvar gr;
  generate
    for (gr = 0; gr < aiar_pkg::NUM_ROLE; gr++)
    begin : g_route
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          routed_val_reg[gr] <= 12'h000;
          routed_vld_reg[gr] <= 1'b0;
        end
        else if (role_a == aiar_pkg::ROLE_CODES[gr])
        begin
          routed_val_reg[gr] <= ain_s2_reg[0];
          routed_vld_reg[gr] <= 1'b1;
        end
        else if (role_b == aiar_pkg::ROLE_CODES[gr])
        begin
          routed_val_reg[gr] <= ain_s2_reg[1];
          routed_vld_reg[gr] <= 1'b1;
        end
        else if (role_c == aiar_pkg::ROLE_CODES[gr])
        begin
          routed_val_reg[gr] <= ain_s2_reg[2];
          routed_vld_reg[gr] <= 1'b1;
        end
        else
        begin
          routed_val_reg[gr] <= 12'h000;
          routed_vld_reg[gr] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // External channel one feedback combine and monitor scaling
  // ----------------------------------------------------------------
  logic signed [13:0] fb_a;
  logic signed [13:0] fb_b;
  logic signed [13:0] fb_sum;
  assign fb_a = {2'b00, routed_val_reg[aiar_pkg::IDX_EXT_FB1]};
  assign fb_b = {2'b00, routed_val_reg[aiar_pkg::IDX_EXT_FB2]};
  assign fb_sum = fb_a + fb_b;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      ext1_fb_reg <= 14'h0000;
    else if (!routed_vld_reg[aiar_pkg::IDX_EXT_FB2])
      ext1_fb_reg <= fb_a;
    else
    begin
      case (combine_reg)
        aiar_pkg::CMB_SUM: ext1_fb_reg <= fb_sum;
        aiar_pkg::CMB_DIFF: ext1_fb_reg <= fb_a - fb_b;
        aiar_pkg::CMB_AVG: ext1_fb_reg <= fb_sum >>> 1;
        aiar_pkg::CMB_MAX: ext1_fb_reg <= (fb_a > fb_b) ? fb_a : fb_b;
        aiar_pkg::CMB_MIN: ext1_fb_reg <= (fb_a < fb_b) ? fb_a : fb_b;
        default: ext1_fb_reg <= fb_a;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      monitor_reg <= 32'h0000_0000;
    else
      monitor_reg <= {4'h0, {16'h0000, routed_val_reg[aiar_pkg::IDX_MONITOR]} * {12'h000, disp_coef_reg}};
  end

  // ----------------------------------------------------------------
  // Wire break detection on the frequency command
  // ----------------------------------------------------------------
  // Raw synchronised samples, no filtering, so the check reacts at once
  assign cur = (freq_src == 2'h2) ? ain_s2_reg[2] : (freq_src == 2'h1) ? ain_s2_reg[1] : ain_s2_reg[0];
  assign win_tick = (win_cnt_reg == WIN_CNT_W_L'(LOSS_WINDOW_CYCLES - 1));
  assign drop_hit = ({4'h0, cur} * 16'h000A) < {4'h0, f1_reg};

  always_comb
  begin
    if (fb_mode_reg != aiar_pkg::FB_RATIO)
      recover_hit = ({4'h0, cur} * 16'h0005) > {4'h0, f1_reg};
    else if (fb_ratio_reg >= aiar_pkg::RATIO_UNITY)
      recover_hit = cur > f1_reg;
    else
      recover_hit = ({7'h00, cur} * 19'h00064) > ({7'h00, f1_reg} * {12'h000, fb_ratio_reg});
  end

  assign loss_evt = (loss_state_reg == aiar_pkg::ST_FOLLOW) && win_tick && drop_hit;
  assign repair_evt = (loss_state_reg == aiar_pkg::ST_LOST) && recover_hit;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n || win_tick)
      win_cnt_reg <= '0;
    else
      win_cnt_reg <= win_cnt_reg + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      loss_state_reg <= aiar_pkg::ST_FOLLOW;
      f1_reg <= 12'h000;
    end
    else
    begin
      case (loss_state_reg)
        aiar_pkg::ST_FOLLOW:
          if (win_tick)
          begin
            if (drop_hit)
              loss_state_reg <= aiar_pkg::ST_LOST;
            else
              f1_reg <= cur;
          end
        aiar_pkg::ST_LOST:
          if (recover_hit)
            loss_state_reg <= aiar_pkg::ST_FOLLOW;
        default: loss_state_reg <= aiar_pkg::ST_FOLLOW;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      freq_reg <= 12'h000;
    else if (loss_state_reg == aiar_pkg::ST_FOLLOW || fb_mode_reg == aiar_pkg::FB_CANCEL)
      freq_reg <= cur;
    else if (fb_mode_reg == aiar_pkg::FB_RATIO)
      freq_reg <= 12'(({7'h00, f1_reg} * {12'h000, fb_ratio_reg}) / 19'h00064);
    else
      freq_reg <= 12'h000;
  end

  // ----------------------------------------------------------------
  // Wishbone slave and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      role_reg <= aiar_pkg::RST_ROLE;
      fb_mode_reg <= aiar_pkg::RST_FB_MODE;
      fb_ratio_reg <= aiar_pkg::RST_FB_RATIO;
      combine_reg <= aiar_pkg::RST_COMBINE;
      mask_reg <= aiar_pkg::RST_MASK;
      disp_coef_reg <= aiar_pkg::RST_DISP_COEF;
    end
    else if (bus_wr)
    begin
      case (wb_adr_i)
        aiar_pkg::OFS_ROLE:
          for (int b = 0; b < 4; b++)
            if (wb_sel_i[b])
              role_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
        aiar_pkg::OFS_FALLBACK:
        begin
          if (wb_sel_i[0] && wb_dat_i[1:0] != 2'h3)
            fb_mode_reg <= wb_dat_i[aiar_pkg::FB_MODE_LSB +: 2];
          if (wb_sel_i[1])
          begin
            if (wb_dat_i[15:8] < {1'b0, aiar_pkg::RATIO_MIN})
              fb_ratio_reg <= aiar_pkg::RATIO_MIN;
            else if (wb_dat_i[15:8] > {1'b0, aiar_pkg::RATIO_MAX})
              fb_ratio_reg <= aiar_pkg::RATIO_MAX;
            else
              fb_ratio_reg <= wb_dat_i[aiar_pkg::FB_RATIO_LSB +: 7];
          end
        end
        aiar_pkg::OFS_COMBINE:
          if (wb_sel_i[0])
            combine_reg <= wb_dat_i[2:0];
        aiar_pkg::OFS_MASK:
          if (wb_sel_i[0])
            mask_reg <= wb_dat_i[1:0];
        aiar_pkg::OFS_DISP_COEF:
        begin
          if (wb_sel_i[0])
            disp_coef_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            disp_coef_reg[15:8] <= wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
  end

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      status_reg <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == aiar_pkg::ST_LOSS_BIT) ? loss_evt : repair_evt)
          status_reg[i] <= 1'b1;
        else if (bus_wr && wb_adr_i == aiar_pkg::OFS_STATUS && wb_sel_i[0] && wb_dat_i[i])
          status_reg[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_reg & mask_reg);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      case (wb_adr_i)
        aiar_pkg::OFS_ROLE: rdata_reg <= role_reg & 32'h033F_3F3F;
        aiar_pkg::OFS_FALLBACK: rdata_reg <= {17'h0, fb_ratio_reg, 6'h00, fb_mode_reg};
        aiar_pkg::OFS_COMBINE: rdata_reg <= {29'h0, combine_reg};
        aiar_pkg::OFS_STATUS: rdata_reg <= {23'h0, (loss_state_reg == aiar_pkg::ST_LOST), 6'h00, status_reg};
        aiar_pkg::OFS_MASK: rdata_reg <= {30'h0, mask_reg};
        aiar_pkg::OFS_MONITOR: rdata_reg <= monitor_reg;
        aiar_pkg::OFS_DISP_COEF: rdata_reg <= {16'h0000, disp_coef_reg};
        aiar_pkg::OFS_LEVEL: rdata_reg <= {4'h0, f1_reg, 4'h0, cur};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign irq = irq_reg;
  assign ref_loss = (loss_state_reg == aiar_pkg::ST_LOST);
  assign freq_cmd_out = freq_reg;
  assign upper_limit_val = routed_val_reg[aiar_pkg::IDX_UPPER];
  assign upper_limit_vld = routed_vld_reg[aiar_pkg::IDX_UPPER];
  assign lower_limit_val = routed_val_reg[aiar_pkg::IDX_LOWER];
  assign lower_limit_vld = routed_vld_reg[aiar_pkg::IDX_LOWER];
  assign pid_fb2_val = routed_val_reg[aiar_pkg::IDX_PID_FB2];
  assign pid_fb2_vld = routed_vld_reg[aiar_pkg::IDX_PID_FB2];
  assign pid_aux1_val = routed_val_reg[aiar_pkg::IDX_PID_AUX1];
  assign pid_aux1_vld = routed_vld_reg[aiar_pkg::IDX_PID_AUX1];
  assign pid_aux2_val = routed_val_reg[aiar_pkg::IDX_PID_AUX2];
  assign pid_aux2_vld = routed_vld_reg[aiar_pkg::IDX_PID_AUX2];
  assign ext1_cmd_val = routed_val_reg[aiar_pkg::IDX_EXT_CMD1];
  assign ext1_cmd_vld = routed_vld_reg[aiar_pkg::IDX_EXT_CMD1];
  assign ext1_fb_val = ext1_fb_reg;
  assign ext1_fb_vld = routed_vld_reg[aiar_pkg::IDX_EXT_FB1];
  assign ext1_man_val = routed_val_reg[aiar_pkg::IDX_EXT_MAN1];
  assign ext1_man_vld = routed_vld_reg[aiar_pkg::IDX_EXT_MAN1];
  assign ext2_cmd_val = routed_val_reg[aiar_pkg::IDX_EXT_CMD2];
  assign ext2_cmd_vld = routed_vld_reg[aiar_pkg::IDX_EXT_CMD2];
  assign ext2_fb_val = routed_val_reg[aiar_pkg::IDX_EXT_FB2];
  assign ext2_fb_vld = routed_vld_reg[aiar_pkg::IDX_EXT_FB2];
  assign ext2_man_val = routed_val_reg[aiar_pkg::IDX_EXT_MAN2];
  assign ext2_man_vld = routed_vld_reg[aiar_pkg::IDX_EXT_MAN2];
  assign ext3_cmd_val = routed_val_reg[aiar_pkg::IDX_EXT_CMD3];
  assign ext3_cmd_vld = routed_vld_reg[aiar_pkg::IDX_EXT_CMD3];
  assign ext3_fb_val = routed_val_reg[aiar_pkg::IDX_EXT_FB3];
  assign ext3_fb_vld = routed_vld_reg[aiar_pkg::IDX_EXT_FB3];
  assign ext3_man_val = routed_val_reg[aiar_pkg::IDX_EXT_MAN3];
  assign ext3_man_vld = routed_vld_reg[aiar_pkg::IDX_EXT_MAN3];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  break_detect_a: assert property (loss_evt |=> ref_loss)
    else $error("break not flagged after window drop");
  sample_keep_a: assert property (win_tick && !ref_loss && !drop_hit |=> f1_reg == $past(cur))
    else $error("reference sample not refreshed");
  wire_repair_a: assert property (ref_loss && recover_hit |=> !ref_loss)
    else $error("repair not taken");
  cancel_pass_a: assert property (ref_loss && fb_mode_reg == aiar_pkg::FB_CANCEL |=> freq_cmd_out == $past(cur))
    else $error("cancel mode altered command");
  decel_hold_a: assert property (ref_loss && fb_mode_reg == aiar_pkg::FB_DECEL && cur > 12'h000
      && ({4'h0, cur} * 16'h0005) <= {4'h0, f1_reg} |=> ref_loss)
    else $error("recovered below fifth of sample");
  unity_hold_a: assert property (ref_loss && fb_mode_reg == aiar_pkg::FB_RATIO
      && fb_ratio_reg >= aiar_pkg::RATIO_UNITY && cur <= f1_reg |=> ref_loss)
    else $error("recovered below sample level");
  ratio_range_a: assert property (fb_ratio_reg >= aiar_pkg::RATIO_MIN && fb_ratio_reg <= aiar_pkg::RATIO_MAX)
    else $error("fallback ratio out of range");
  upper_route_a: assert property (role_a == 6'h0D ##1 role_a == 6'h0D |=> upper_limit_vld
      && upper_limit_val == $past(ain_s2_reg[0]))
    else $error("upper limit not routed from terminal A");
  route_prio_a: assert property (role_a == 6'h29 && role_b == 6'h29 |=> ext1_cmd_val == $past(ain_s2_reg[0]))
    else $error("terminal A lost priority");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule // aiar_router

// ==== hdl/aiar_pkg.sv ====
// Constants and types for the analog input role router with reference loss detection
package aiar_pkg;

  // ----------------------------------------------------------------
  // Data widths
  // ----------------------------------------------------------------
  localparam int ADC_W = 12;
  localparam int ROLE_W = 6;
  localparam int NUM_TERM = 3;
  localparam int NUM_ROLE = 15;

  // ----------------------------------------------------------------
  // Role codes, one per routed destination
  // ----------------------------------------------------------------
  localparam logic [5:0] ROLE_CODES [NUM_ROLE] = '{
    6'h0D, 6'h0E, 6'h14, 6'h1E, 6'h1F, 6'h20,
    6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h30, 6'h31};
  localparam int IDX_UPPER = 0;
  localparam int IDX_LOWER = 1;
  localparam int IDX_MONITOR = 2;
  localparam int IDX_PID_FB2 = 3;
  localparam int IDX_PID_AUX1 = 4;
  localparam int IDX_PID_AUX2 = 5;
  localparam int IDX_EXT_CMD1 = 6;
  localparam int IDX_EXT_FB1 = 7;
  localparam int IDX_EXT_MAN1 = 8;
  localparam int IDX_EXT_CMD2 = 9;
  localparam int IDX_EXT_FB2 = 10;
  localparam int IDX_EXT_MAN2 = 11;
  localparam int IDX_EXT_CMD3 = 12;
  localparam int IDX_EXT_FB3 = 13;
  localparam int IDX_EXT_MAN3 = 14;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ROLE = 8'h00;
  localparam logic [7:0] OFS_FALLBACK = 8'h04;
  localparam logic [7:0] OFS_COMBINE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_MONITOR = 8'h14;
  localparam logic [7:0] OFS_DISP_COEF = 8'h18;
  localparam logic [7:0] OFS_LEVEL = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ROLE_A_LSB = 0;
  localparam int ROLE_B_LSB = 8;
  localparam int ROLE_C_LSB = 16;
  localparam int FREQ_SRC_LSB = 24;
  localparam int FB_MODE_LSB = 0;
  localparam int FB_RATIO_LSB = 8;
  localparam int ST_LOSS_BIT = 0;
  localparam int ST_REPAIR_BIT = 1;
  localparam int ST_LIVE_BIT = 8;
  localparam int LEVEL_F1_LSB = 16;

  // ----------------------------------------------------------------
  // Fallback modes and combine operations
  // ----------------------------------------------------------------
  localparam logic [1:0] FB_DECEL = 2'h0;
  localparam logic [1:0] FB_RATIO = 2'h1;
  localparam logic [1:0] FB_CANCEL = 2'h2;
  localparam logic [6:0] RATIO_MIN = 7'h14;
  localparam logic [6:0] RATIO_MAX = 7'h78;
  localparam logic [6:0] RATIO_UNITY = 7'h64;
  localparam logic [2:0] CMB_NONE = 3'h0;
  localparam logic [2:0] CMB_SUM = 3'h1;
  localparam logic [2:0] CMB_DIFF = 3'h2;
  localparam logic [2:0] CMB_AVG = 3'h3;
  localparam logic [2:0] CMB_MAX = 3'h4;
  localparam logic [2:0] CMB_MIN = 3'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ROLE = 32'h0000_0000;
  localparam logic [1:0] RST_FB_MODE = FB_DECEL;
  localparam logic [6:0] RST_FB_RATIO = RATIO_UNITY;
  localparam logic [2:0] RST_COMBINE = CMB_NONE;
  localparam logic [1:0] RST_MASK = 2'h0;
  localparam logic [15:0] RST_DISP_COEF = 16'h0100;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int LOSS_WINDOW_MS = 400;
  localparam int LOSS_WINDOW_CYCLES = LOSS_WINDOW_MS * (CLK_HZ / 1000);
  localparam int WIN_CNT_W = 24;

  typedef enum logic {ST_FOLLOW, ST_LOST} aiar_loss_state_t;

endpackage

// ==== test/aiar_sensor.sv ====
// Far-side model: three analog sensors feeding the terminals
`timescale 1ns/100ps
module aiar_sensor (
  input wire logic core_clk,
  input wire logic jump,
  input wire logic [11:0] tgt [3],
  output logic [11:0] lvl [3]
);
  initial lvl = '{3{12'h000}};
  always @(posedge core_clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (jump || (lvl[i] + 13'h040 > tgt[i] && tgt[i] + 13'h040 > lvl[i]))
        lvl[i] <= tgt[i];
      else
        lvl[i] <= (lvl[i] < tgt[i]) ? lvl[i] + 12'h040 : lvl[i] - 12'h040;
    end
  end
endmodule  // aiar_sensor

// ==== test/aiar_router_test.sv ====
// Self-checking bench for the analog input role router
`timescale 1ns/100ps
module aiar_router_test;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, jump = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rnd = 32'h0000_2480, dat_o;
  logic [31:0] exp_q [$];
  logic [11:0] tgt [3] = '{3{12'h000}};
  logic [11:0] lvl [3];
  logic [11:0] fco;
  logic [13:0] fb1;
  logic ack, irq, ref_loss;
  wire [11:0] v [15];
  wire [14:0] vld;
  int bad_count = 0, n_compared = 0;
  always #25 core_clk = ~core_clk;
  aiar_sensor i_aiar_sensor (.core_clk(core_clk), .jump(jump), .tgt(tgt), .lvl(lvl));
  aiar_router #(.LOSS_WINDOW_CYCLES(16)) i_aiar_router (
    .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .analog_in_a(lvl[0]), .current_input_b(lvl[1]), .voltage_input_c(lvl[2]),
    .upper_limit_val(v[0]), .upper_limit_vld(vld[0]), .lower_limit_val(v[1]), .lower_limit_vld(vld[1]),
    .pid_fb2_val(v[3]), .pid_fb2_vld(vld[3]), .pid_aux1_val(v[4]), .pid_aux1_vld(vld[4]),
    .pid_aux2_val(v[5]), .pid_aux2_vld(vld[5]), .ext1_cmd_val(v[6]), .ext1_cmd_vld(vld[6]),
    .ext1_fb_val(fb1), .ext1_fb_vld(vld[7]), .ext1_man_val(v[8]), .ext1_man_vld(vld[8]),
    .ext2_cmd_val(v[9]), .ext2_cmd_vld(vld[9]), .ext2_fb_val(v[10]), .ext2_fb_vld(vld[10]),
    .ext2_man_val(v[11]), .ext2_man_vld(vld[11]), .ext3_cmd_val(v[12]), .ext3_cmd_vld(vld[12]),
    .ext3_fb_val(v[13]), .ext3_fb_vld(vld[13]), .ext3_man_val(v[14]), .ext3_man_vld(vld[14]),
    .freq_cmd_out(fco), .ref_loss(ref_loss), .irq(irq));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [13:0] cmb(input int m);
    logic [13:0] a, b;
    a = {2'b00, tgt[0]};
    b = {2'b00, tgt[1]};
    case (m)
      1: return a + b;
      2: return a - b;
      3: return (a + b) >> 1;
      4: return (a > b) ? a : b;
      default: return (a < b) ? a : b;
    endcase
  endfunction
  task automatic tally_and_finish;
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read requests carry their expected data in d
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    if (!w) exp_q.push_back(d);
    @(posedge core_clk);
    while (ack !== 1'b1) @(posedge core_clk);
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic lv(input logic j, input logic [11:0] a, input int n);
    jump <= j;
    tgt[0] <= a;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic loss(input logic [31:0] fb, input logic [11:0] o, input logic [11:0] lo, input logic [11:0] hi);
    wb(1'b1, 8'h04, fb);
    lv(1'b0, 12'h3E8, 100);
    wb(1'b1, 8'h0C, 32'h0000_0003);
    lv(1'b1, 12'h032, 24);
    chk("ref_loss", 32'h1, ref_loss);
    chk("freq_cmd_out", o, fco);
    chk("irq", 32'h1, irq);
    wb(1'b0, 8'h0C, 32'h0000_0101);
    lv(1'b0, lo, 80);
    chk("ref_loss", 32'h1, ref_loss);
    lv(1'b0, hi, 80);
    chk("ref_loss", 32'h0, ref_loss);
    chk("freq_cmd_out", hi, fco);
    wb(1'b0, 8'h0C, 32'h0000_0003);
    wb(1'b1, 8'h0C, 32'h0000_0003);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk("irq", 32'h0, irq);
  endtask
  // ----------------------------------------------------------------
  // Read checker, watchdog and main sequence
  // ----------------------------------------------------------------
  always @(posedge core_clk)
    if (ack === 1'b1 && we === 1'b0) chk("wb_dat_o", exp_q.pop_front(), dat_o);
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    tally_and_finish;
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    wb(1'b0, 8'h04, 32'h0000_6400);
    wb(1'b0, 8'h18, 32'h0000_0100);
    wb(1'b0, 8'h20, 32'h0000_0000);
    for (int i = 0; i < 15; i++)
    begin
      rnd = xs(rnd);
      jump <= 1'b1;
      tgt <= '{rnd[11:0], rnd[23:12], rnd[31:20]};
      wb(1'b1, 8'h00, {26'h0, aiar_pkg::ROLE_CODES[i]});
      repeat (6) @(posedge core_clk);
      chk("vld", 15'h0004 | (15'h0001 << i), vld | 15'h0004);
      if (i == 2) wb(1'b0, 8'h14, {4'h0, rnd[11:0], 8'h00});
      else if (i == 7) chk("ext1_fb_val", {2'b00, rnd[11:0]}, fb1);
      else chk("val", rnd[11:0], v[i]);
    end
    wb(1'b1, 8'h00, 32'h0029_2929);
    repeat (6) @(posedge core_clk);
    chk("ext1_cmd_val", tgt[0], v[6]);
    wb(1'b1, 8'h00, 32'h0029_2900);
    repeat (6) @(posedge core_clk);
    chk("ext1_cmd_val", tgt[1], v[6]);
    wb(1'b1, 8'h00, 32'h0000_2D2A);
    for (int m = 1; m < 6; m++)
    begin
      wb(1'b1, 8'h08, 32'(m));
      repeat (6) @(posedge core_clk);
      chk("ext1_fb_val", cmb(m), fb1);
    end
    wb(1'b1, 8'h04, 32'h0000_0A01);
    wb(1'b0, 8'h04, 32'h0000_1401);
    wb(1'b1, 8'h04, 32'h0000_7F03);
    wb(1'b0, 8'h04, 32'h0000_7801);
    wb(1'b1, 8'h10, 32'h0000_0003);
    lv(1'b0, 12'h7D0, 100);
    wb(1'b1, 8'h0C, 32'h0000_0003);
    loss(32'h0000_6400, 12'h000, 12'h0BE, 12'h0D2);
    loss(32'h0000_3201, 12'h1F4, 12'h1F4, 12'h1FE);
    loss(32'h0000_7801, 12'h4B0, 12'h3E8, 12'h3F2);
    loss(32'h0000_6402, 12'h032, 12'h0BE, 12'h0D2);
    tally_and_finish;
  end
endmodule  // aiar_router_test
